/* File: core/cdt_pkg.sv */
package cdt_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] CDT_CTRL_ADDR = 8'h00;
	localparam logic [7:0] CDT_STAT_ADDR = 8'h04;
	localparam logic [7:0] CDT_RLD0_ADDR = 8'h10;
	localparam logic [7:0] CDT_CNT0_ADDR = 8'h14;
	localparam logic [7:0] CDT_RLD1_ADDR = 8'h18;
	localparam logic [7:0] CDT_CNT1_ADDR = 8'h1c;
	localparam logic [7:0] CDT_RLD2_ADDR = 8'h20;
	localparam logic [7:0] CDT_CNT2_ADDR = 8'h24;
	localparam logic [7:0] CDT_RLD3_ADDR = 8'h28;
	localparam logic [7:0] CDT_CNT3_ADDR = 8'h2c;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CDT_EN0_BIT = 0;
	localparam int CDT_EN1_BIT = 1;
	localparam int CDT_EN23_BIT = 2;
	localparam int CDT_AR0_BIT = 4;
	localparam int CDT_AR1_BIT = 5;
	localparam int CDT_AR23_BIT = 6;
	localparam int CDT_CASC_BIT = 8;
	localparam int CDT_OUTSEL_BIT = 9;
	localparam logic [9:0] CDT_CTRL_RESET = 10'h000;
	localparam logic [7:0] CDT_REG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Status register fields (sticky zero flags, write one to clear)
	// ----------------------------------------------------------------
	localparam int CDT_ZF0_BIT = 0;
	localparam int CDT_ZF1_BIT = 1;
	localparam int CDT_ZF23_BIT = 2;

	// ----------------------------------------------------------------
	// Timing: 10 MHz clock, count tick prescale
	// ----------------------------------------------------------------
	localparam int CDT_CLK_HZ = 10000000;
	localparam int CDT_TICK_HZ = 10000000;
	localparam logic [7:0] CDT_PRESCALE = 8'((CDT_CLK_HZ / CDT_TICK_HZ) - 1);

	// AXI response codes.
	localparam logic [1:0] CDT_RESP_OKAY = 2'h0;
	localparam logic [1:0] CDT_RESP_SLVERR = 2'h2;

	// Register write request carried to the counters.
	typedef struct packed {
		logic wrCnt;
		logic wrRld;
		logic [7:0] data;
	} cdt_wr_t;

	// Counter state carried back.
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] rld;
	} cdt_val_t;

endpackage : cdt_pkg

/* File: core/cdt_byte_timer.sv */
`timescale 1ns/1ps
// One 8-bit down-counter with its reload register.
module cdt_byte_timer (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Counting control
	input wire logic dec,
	input wire logic reload,
	// Software access
	input wire cdt_pkg::cdt_wr_t wr,
	output cdt_pkg::cdt_val_t val
);
	import cdt_pkg::*;

	logic [7:0] cnt_reg;
	logic [7:0] rld_reg;

	// Count register: software write beats reload and decrement.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= CDT_REG_RESET;
		end else if (wr.wrCnt) begin
			cnt_reg <= wr.data; // [R9] [R11]
		end else if (reload) begin
			cnt_reg <= rld_reg; // [R8] [R10]
		end else if (dec) begin
			cnt_reg <= cnt_reg - 8'h01; // [R5]
		end
	end

	// Reload register holds only what software writes.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rld_reg <= CDT_REG_RESET;
		end else if (wr.wrRld) begin
			rld_reg <= wr.data; // [R4]
		end
	end

	assign val = '{cnt: cnt_reg, rld: rld_reg};

endmodule : cdt_byte_timer

/* File: core/cdt_timers.sv */
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Operation
// [R1] Timers one and two run independently 8-bit
// [R2] Optional cascade: second high, first low
// [R3] Third and fourth always one 16-bit
// [R4] Each timer: reload and count registers
// [R5] Enabled timer decrements until zero
// [R6] Zero raises that timer's interrupt
// [R7] No reload: stop, clear enable bit
// [R8] Reload: copy reload value, keep counting
// [R9] Written count continues from new value
// [R10] Changed reload used at next zero
// [R11] Software write beats decrementer write-back
// [R12] Hardware enable clear beats software write
// [R13] Reads never disturb timer operation
// [R14] Reset leaves all timers disabled
// [R15] Software avoids writes at zero crossing
// [R16] Timer registers used only for timing
// [R17] First timer output routable to pin
// [R18] Halt keeps timers counting
// [R19] Stop freezes timers, clock off
// [R20] Cascade borrows; terminal when both zero
// [R21] Synchronous tick enable, rising edge updates
module cdt_timers (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Power state
	input wire logic stopMode,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Timer events and pin output
	output logic [2:0] timerIrq,
	output logic timerOut,
	output logic timerOutSel
);
	import cdt_pkg::*;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic awHeld_reg;
	logic wHeld_reg;
	logic [7:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic bValid_reg;
	logic [1:0] bResp_reg;
	logic rValid_reg;
	logic [31:0] rData_reg;
	logic [1:0] rResp_reg;
	logic doWrite;
	logic wrLow;
	logic wrMapped;

	assign s_axi_awready = !awHeld_reg && !bValid_reg;
	assign s_axi_wready = !wHeld_reg && !bValid_reg;
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_arready = !rValid_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rdata = rData_reg;
	assign s_axi_rresp = rResp_reg;
	assign doWrite = awHeld_reg && wHeld_reg;
	assign wrLow = doWrite && wStrb_reg[0];

	// Address and data may arrive in either order; both are held.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_reg <= 1'b0;
			end
		end
	end

	// Decode whether the write address is mapped.
	always_comb begin
		case (awAddr_reg)
			CDT_CTRL_ADDR, CDT_STAT_ADDR, CDT_RLD0_ADDR, CDT_CNT0_ADDR,
			CDT_RLD1_ADDR, CDT_CNT1_ADDR, CDT_RLD2_ADDR, CDT_CNT2_ADDR,
			CDT_RLD3_ADDR, CDT_CNT3_ADDR: wrMapped = 1'b1;
			default: wrMapped = 1'b0;
		endcase
	end

	// Write response one cycle after both halves are held.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bValid_reg <= 1'b0;
			bResp_reg <= CDT_RESP_OKAY;
		end else if (doWrite) begin
			bValid_reg <= 1'b1;
			bResp_reg <= wrMapped ? CDT_RESP_OKAY : CDT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Control, status and tick
	// ----------------------------------------------------------------
	logic [9:0] ctrl_reg;
	logic [2:0] zflag_reg;
	logic [7:0] pre_reg;
	logic tick;
	logic [2:0] zeroEvt;
	logic [2:0] stopEvt;
	logic casc;
	cdt_wr_t wr [4];
	cdt_val_t val [4];

	assign casc = ctrl_reg[CDT_CASC_BIT];

	// Count enable pulse; frozen while the clock is stopped.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pre_reg <= 8'h00;
		end else if (!stopMode) begin
			pre_reg <= (pre_reg == CDT_PRESCALE) ? 8'h00 : pre_reg + 8'h01; // [R21] [R18]
		end
	end
	assign tick = !stopMode && (pre_reg == CDT_PRESCALE); // [R19] [R21]

	// Control bits: hardware clear of an enable wins over software.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= CDT_CTRL_RESET; // [R14]
		end else begin
			if (wrLow && awAddr_reg == CDT_CTRL_ADDR) begin
				ctrl_reg <= {wData_reg[9:8], 1'b0, wData_reg[6:4], 1'b0, wData_reg[2:0]};
			end
			if (stopEvt[0]) begin
				ctrl_reg[CDT_EN0_BIT] <= 1'b0; // [R7] [R12]
			end
			if (stopEvt[1]) begin
				ctrl_reg[CDT_EN1_BIT] <= 1'b0; // [R7] [R12]
			end
			if (stopEvt[2]) begin
				ctrl_reg[CDT_EN23_BIT] <= 1'b0; // [R7] [R12]
			end
		end
	end

	// Sticky zero flags; a new event wins over the clear.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			zflag_reg <= 3'h0;
		end else begin
			zflag_reg <= (zflag_reg & ~((wrLow && awAddr_reg == CDT_STAT_ADDR)
				? wData_reg[2:0] : 3'h0)) | zeroEvt; // [R6]
		end
	end

	// ----------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------
	logic en0;
	logic en1;
	logic en23;
	logic z0;
	logic z1;
	logic z2;
	logic z3;
	logic [3:0] dec;
	logic [3:0] rel;

	assign en0 = ctrl_reg[CDT_EN0_BIT];
	assign en1 = casc ? ctrl_reg[CDT_EN0_BIT] : ctrl_reg[CDT_EN1_BIT];
	assign en23 = ctrl_reg[CDT_EN23_BIT];
	assign z0 = val[0].cnt == 8'h00;
	assign z1 = val[1].cnt == 8'h00;
	assign z2 = val[2].cnt == 8'h00;
	assign z3 = val[3].cnt == 8'h00;

	// Terminal events per channel: pair terminates only when both bytes are zero.
	always_comb begin
		zeroEvt = 3'h0;
		if (casc) begin
			zeroEvt[0] = tick && en0 && z0 && z1; // [R2] [R20]
		end else begin
			zeroEvt[0] = tick && en0 && z0; // [R1]
			zeroEvt[1] = tick && en1 && z1; // [R1]
		end
		zeroEvt[2] = tick && en23 && z2 && z3; // [R3] [R20]
		stopEvt[0] = zeroEvt[0] && !ctrl_reg[CDT_AR0_BIT];
		stopEvt[1] = zeroEvt[1] && !ctrl_reg[CDT_AR1_BIT];
		stopEvt[2] = zeroEvt[2] && !ctrl_reg[CDT_AR23_BIT];
	end

	// Decrement and reload strobes; low byte borrows from the high byte.
	always_comb begin
		rel[0] = zeroEvt[0] && ctrl_reg[CDT_AR0_BIT]; // [R8]
		rel[1] = casc ? rel[0] : (zeroEvt[1] && ctrl_reg[CDT_AR1_BIT]);
		rel[2] = zeroEvt[2] && ctrl_reg[CDT_AR23_BIT];
		rel[3] = rel[2];
		dec[0] = tick && en0 && !zeroEvt[0]; // [R5]
		dec[1] = casc ? (dec[0] && z0) : (tick && en1 && !zeroEvt[1]); // [R20]
		dec[2] = tick && en23 && !zeroEvt[2];
		dec[3] = dec[2] && z2; // [R20]
	end

	// Software writes to the counter registers, byte lane zero.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wr[i].data = wData_reg[7:0];
			wr[i].wrRld = wrLow && (awAddr_reg == CDT_RLD0_ADDR + 8'(8 * i));
			wr[i].wrCnt = wrLow && (awAddr_reg == CDT_CNT0_ADDR + 8'(8 * i)); // [R11]
		end
	end

	for (genvar g = 0; g < 4; g++) begin : gTimer
		cdt_byte_timer uTimer (
			.clock(clock),
			.rstn(rstn),
			.dec(dec[g]),
			.reload(rel[g]),
			.wr(wr[g]),
			.val(val[g])
		);
	end

	// ----------------------------------------------------------------
	// Read path and outputs
	// ----------------------------------------------------------------
	// Reads only sample state, so timing is never disturbed.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rValid_reg <= 1'b0;
			rData_reg <= 32'h0000_0000;
			rResp_reg <= CDT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rValid_reg <= 1'b1;
			rResp_reg <= CDT_RESP_OKAY;
			case (s_axi_araddr)
				CDT_CTRL_ADDR: rData_reg <= {22'h0, ctrl_reg};
				CDT_STAT_ADDR: rData_reg <= {29'h0, zflag_reg};
				CDT_RLD0_ADDR: rData_reg <= {24'h0, val[0].rld}; // [R13]
				CDT_CNT0_ADDR: rData_reg <= {24'h0, val[0].cnt}; // [R13]
				CDT_RLD1_ADDR: rData_reg <= {24'h0, val[1].rld};
				CDT_CNT1_ADDR: rData_reg <= {24'h0, val[1].cnt};
				CDT_RLD2_ADDR: rData_reg <= {24'h0, val[2].rld};
				CDT_CNT2_ADDR: rData_reg <= {24'h0, val[2].cnt};
				CDT_RLD3_ADDR: rData_reg <= {24'h0, val[3].rld};
				CDT_CNT3_ADDR: rData_reg <= {24'h0, val[3].cnt};
				default: begin
					rData_reg <= 32'h0000_0000;
					rResp_reg <= CDT_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rValid_reg <= 1'b0;
		end
	end

	// Interrupt pulses and the first timer's toggling pin output.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			timerIrq <= 3'h0;
			timerOut <= 1'b0;
		end else begin
			timerIrq <= zeroEvt; // [R6]
			if (zeroEvt[0]) begin
				timerOut <= !timerOut; // [R17]
			end
		end
	end
	assign timerOutSel = ctrl_reg[CDT_OUTSEL_BIT]; // [R17]

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Counting, control and bus checks.
	a_irq_follows_zero: assert property (@(posedge clock) disable iff (!rstn) // [R6]
		zeroEvt[0] |=> timerIrq[0]) else $error("irq0 missing after zero");
	a_oneshot_clears_en: assert property (@(posedge clock) disable iff (!rstn) // [R7]
		stopEvt[0] |=> !ctrl_reg[CDT_EN0_BIT]) else $error("en0 not cleared");
	a_enable_clear_wins: assert property (@(posedge clock) disable iff (!rstn) // [R12]
		(stopEvt[2] && wrLow && awAddr_reg == CDT_CTRL_ADDR && wData_reg[2])
		|=> !ctrl_reg[CDT_EN23_BIT]) else $error("sw beat hw clear");
	a_reload_copies: assert property (@(posedge clock) disable iff (!rstn) // [R8]
		(rel[0] && !wr[0].wrCnt) |=> val[0].cnt == $past(val[0].rld))
		else $error("reload value wrong");
	a_decrement_step: assert property (@(posedge clock) disable iff (!rstn) // [R5]
		(dec[2] && !wr[2].wrCnt && !rel[2]) |=> val[2].cnt == $past(val[2].cnt) - 8'h01)
		else $error("decrement wrong");
	a_sw_write_wins: assert property (@(posedge clock) disable iff (!rstn) // [R11]
		wr[1].wrCnt |=> val[1].cnt == $past(wData_reg[7:0]))
		else $error("sw count write lost");
	a_stop_freezes: assert property (@(posedge clock) disable iff (!rstn) // [R19]
		(stopMode && !wr[3].wrCnt) |=> $stable(val[3].cnt)) else $error("count moved in stop");
	a_pair_terminal: assert property (@(posedge clock) disable iff (!rstn) // [R20]
		timerIrq[2] |-> ($past(val[2].cnt) == 8'h00 && $past(val[3].cnt) == 8'h00))
		else $error("early pair terminal");
	a_cascade_borrow: assert property (@(posedge clock) disable iff (!rstn) // [R20]
		(casc && dec[0] && z0 && !wr[1].wrCnt)
		|=> val[1].cnt == $past(val[1].cnt) - 8'h01) else $error("high byte borrow missing");
	a_cascade_hold: assert property (@(posedge clock) disable iff (!rstn) // [R2]
		(casc && tick && en0 && !z0 && !wr[1].wrCnt)
		|=> $stable(val[1].cnt)) else $error("high byte moved early");
	a_read_answers: assert property (@(posedge clock) disable iff (!rstn) // [R13]
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("no read answer");

	// Cover points for the main scenarios.
	c_oneshot: cover property (@(posedge clock) disable iff (!rstn) stopEvt[0]);
	c_reload: cover property (@(posedge clock) disable iff (!rstn) rel[2]);
	c_cascade: cover property (@(posedge clock) disable iff (!rstn) casc && zeroEvt[0]);
	c_write_read: cover property (@(posedge clock) disable iff (!rstn) doWrite ##[1:8] rValid_reg);

endmodule : cdt_timers

/* File: tb/tb_cascadable_down_timers.sv */
`timescale 1ns/1ps
module tb_cascadable_down_timers;
	import cdt_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic stopMode = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] timerIrq;
	logic timerOut, timerOutSel;
	int errCount = 0;
	int checks = 0;
	int irqCount [3] = '{0, 0, 0};

	// The clock runs at 10 MHz.
	always #50 clock = ~clock;

	// Unit under test; write strobes stay fully on.
	cdt_timers uut (
		.clock(clock), .rstn(rstn), .stopMode(stopMode),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .timerIrq(timerIrq),
		.timerOut(timerOut), .timerOutSel(timerOutSel)
	);

	// Counts the one-cycle pulses on each of the three interrupt lines.
	always @(posedge clock) begin
		for (int i = 0; i < 3; i++) begin
			if (timerIrq[i] === 1'b1) irqCount[i]++;
		end
	end

	// ----------------------------------------------------------------
	// Reporting
	// ----------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	// Compares a bus word.
	task automatic cmpWord(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errCount++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : cmpWord

	// Compares a count measured by the bench.
	task automatic cmpNum(input string n, input int e, input int g);
		checks++;
		if (g != e) begin
			errCount++;
			$display("unexpected %s: expected %0d seen %0d", n, e, g);
		end
	endtask : cmpNum

	// Ends the run when a bounded wait ran out.
	task automatic hang(input string n);
		errCount++;
		$display("unexpected %s: expected answer seen none", n);
		results();
	endtask : hang

	// ----------------------------------------------------------------
	// AXI4-Lite master
	// ----------------------------------------------------------------
	// One write: address and data offered together, each dropped when taken.
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		if (bvalid !== 1'b1) hang("bvalid");
		r = bresp;
		bready <= 1'b0;
	endtask : axiWrite

	// One read: the answer is taken at the edge that shows rvalid.
	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		if (rvalid !== 1'b1) hang("rvalid");
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axiRead

	// Write expecting an OKAY response.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axiWrite(a, d, r);
		cmpWord("bresp", {30'h0, CDT_RESP_OKAY}, {30'h0, r});
	endtask : wr

	// Read expecting an OKAY response and the given word.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axiRead(a, d, r);
		cmpWord("rresp", {30'h0, CDT_RESP_OKAY}, {30'h0, r});
		cmpWord("rdata", e, d);
	endtask : rd

	// Waits for a pulse on one interrupt line, bounded.
	task automatic waitIrq(input int b, input int lim);
		int n;
		n = 0;
		while (timerIrq[b] !== 1'b1) begin
			@(posedge clock);
			n++;
			if (n > lim) hang("timerIrq");
		end
	endtask : waitIrq

	// Cycles between two pulses, and whether the pin output toggled once.
	task automatic period(input int b, output int p, output logic t);
		logic o;
		@(posedge clock);
		waitIrq(b, 2000);
		o = timerOut;
		p = 0;
		do begin
			@(posedge clock);
			p++;
		end while (timerIrq[b] !== 1'b1 && p < 2000);
		t = (timerOut !== o);
	endtask : period

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic t;
		int p;
		int c;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		// Reset state, then every reload and count register written and read back.
		for (int i = 0; i < 12; i++) if (i != 2 && i != 3) rd(8'(4 * i), 32'h0);
		for (int i = 4; i < 12; i++) wr(8'(4 * i), 32'(17 * i));
		for (int i = 4; i < 12; i++) rd(8'(4 * i), 32'(17 * i));
		// Unmapped places are refused.
		axiWrite(8'h08, 32'h1, r);
		cmpWord("bresp", {30'h0, CDT_RESP_SLVERR}, {30'h0, r});
		axiRead(8'h3c, d, r);
		cmpWord("rresp", {30'h0, CDT_RESP_SLVERR}, {30'h0, r});
		cmpWord("rdata", 32'h0, d);
		// First timer alone, auto-reload, pin output selected.
		wr(CDT_RLD0_ADDR, 32'h3);
		wr(CDT_CNT0_ADDR, 32'h3);
		wr(CDT_CTRL_ADDR, 32'h211);
		period(0, p, t);
		cmpNum("period0", 4, p);
		cmpWord("timerOut toggle", 32'h1, {31'h0, t});
		cmpWord("timerOutSel", 32'h1, {31'h0, timerOutSel});
		rd(CDT_CTRL_ADDR, 32'h211);
		// A new reload value takes over at a later zero.
		wr(CDT_RLD0_ADDR, 32'h7);
		period(0, p, t);
		period(0, p, t);
		cmpNum("period0 new", 8, p);
		// Reads while running leave the period alone.
		fork
			period(0, p, t);
			repeat (3) axiRead(CDT_CNT0_ADDR, d, r);
		join
		cmpNum("period0 read", 8, p);
		// Stopped clock freezes the timer; it resumes afterwards.
		stopMode <= 1'b1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		c = irqCount[0];
		repeat (40) @(posedge clock);
		@(negedge clock);
		cmpNum("irq0 stopped", c, irqCount[0]);
		@(posedge clock);
		stopMode <= 1'b0;
		waitIrq(0, 20);
		wr(CDT_CTRL_ADDR, 32'h0);
		// Cascaded pair: second timer high byte, first low byte.
		wr(CDT_RLD1_ADDR, 32'h1);
		wr(CDT_RLD0_ADDR, 32'h5);
		wr(CDT_CNT1_ADDR, 32'h1);
		wr(CDT_CNT0_ADDR, 32'h5);
		c = irqCount[1];
		wr(CDT_CTRL_ADDR, 32'h111);
		period(0, p, t);
		cmpNum("pair period", 262, p);
		cmpNum("irq1 in cascade", c, irqCount[1]);
		wr(CDT_CTRL_ADDR, 32'h0);
		// Wide timer: fourth timer high byte, third low byte.
		wr(CDT_RLD3_ADDR, 32'h1);
		wr(CDT_RLD2_ADDR, 32'h2);
		wr(CDT_CNT3_ADDR, 32'h1);
		wr(CDT_CNT2_ADDR, 32'h2);
		wr(CDT_CTRL_ADDR, 32'h44);
		period(2, p, t);
		cmpNum("wide period", 259, p);
		wr(CDT_CTRL_ADDR, 32'h0);
		// Single shot on the second timer, count rewritten while running.
		wr(CDT_STAT_ADDR, 32'h7);
		wr(CDT_CNT1_ADDR, 32'hf0);
		wr(CDT_CTRL_ADDR, 32'h2);
		wr(CDT_CNT1_ADDR, 32'h3);
		waitIrq(1, 30);
		repeat (3) @(posedge clock);
		rd(CDT_CTRL_ADDR, 32'h0);
		rd(CDT_CNT1_ADDR, 32'h0);
		rd(CDT_STAT_ADDR, 32'h2);
		@(negedge clock);
		c = irqCount[1];
		repeat (20) @(posedge clock);
		@(negedge clock);
		cmpNum("irq1 after stop", c, irqCount[1]);
		wr(CDT_STAT_ADDR, 32'h2);
		rd(CDT_STAT_ADDR, 32'h0);
		// A reset in mid-run leaves every timer disabled and the first timer's count and reload cleared.
		wr(CDT_CTRL_ADDR, 32'h15);
		@(posedge clock);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		rd(CDT_CTRL_ADDR, 32'h0);
		rd(CDT_CNT0_ADDR, 32'h0);
		rd(CDT_RLD0_ADDR, 32'h0);
		results();
	end

endmodule : tb_cascadable_down_timers
